// *** logic/complementary_waveform_shutdown_ctrl.sv ***
// Complementary waveform generator with auto-shutdown and APB registers
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
module complementary_waveform_shutdown_ctrl
	import complementary_generator_pkg::*;
#(
	parameter int DB_W = 6
)
(
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        pulse_source_one_i,
	input  wire logic        pulse_source_two_i,
	input  wire logic        comparator_one_raw_i,
	input  wire logic        comparator_two_raw_i,
	input  wire logic        fault_pin_n_i,
	output logic             out_a_o,
	output logic             out_a_oe_o,
	output logic             out_b_o,
	output logic             out_b_oe_o
);

	if (DB_W < 1 || DB_W > 6)
	begin : width_check
		$error("complementary_waveform_shutdown_ctrl: DB_W must be 1 to 6");
	end

	// ==================================================================
	// Override level for one output in shutdown
	function automatic logic override_level(input logic [1:0] code,
		input logic invert);
		logic lvl;
		lvl = 1'b0;
		unique case (code)
			LVL_HIGH:     lvl = 1'b1;
			LVL_LOW:      lvl = 1'b0;
			LVL_TRI:      lvl = 1'b0;
			LVL_INACTIVE: lvl = invert;
		endcase
		return lvl;
	endfunction

	// ==================================================================
	// APB slave
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic [7:0]  con0_q;
	logic [7:0]  con1_q;
	logic [7:0]  con2_q;
	logic        ase_q;
	logic [5:0]  dbr_q;
	logic [5:0]  dbf_q;

	wire access   = psel_i & penable_i;
	wire answer   = access & ~pready_q;
	wire done     = access & pready_q;
	wire wr       = done & pwrite_i;
	wire hit_con0 = (paddr_i == OFF_CON0);
	wire hit_con1 = (paddr_i == OFF_CON1);
	wire hit_con2 = (paddr_i == OFF_CON2);
	wire hit_dbr  = (paddr_i == OFF_DBR);
	wire hit_dbf  = (paddr_i == OFF_DBF);
	wire mapped   = hit_con0 | hit_con1 | hit_con2 | hit_dbr | hit_dbf;
	wire wr_con0  = wr & hit_con0;
	wire wr_con1  = wr & hit_con1;
	wire wr_con2  = wr & hit_con2;
	wire wr_dbr   = wr & hit_dbr;
	wire wr_dbf   = wr & hit_dbf;

	wire [7:0] rd_con2 = con2_q | {ase_q, 7'h00};
	wire [7:0] rd_byte =
		hit_con0 ? (con0_q & CON0_MASK) :
		hit_con1 ? (con1_q & CON1_MASK) :
		hit_con2 ? (rd_con2 & (CON2_MASK | 8'h80)) :
		hit_dbr  ? {2'b00, dbr_q} :
		hit_dbf  ? {2'b00, dbf_q} : 8'h00;
	wire [31:0] rd_data = {24'h000000, rd_byte};

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h00000000;
		end
		else
		begin
			pready_q  <= answer;
			pslverr_q <= answer & ~mapped;
			if (answer && !pwrite_i)
			begin
				prdata_q <= rd_data;
			end
		end
	end

	// ==================================================================
	// Control registers
	wire       en    = con0_q[EN_BIT];
	wire       oeb   = con0_q[OEB_BIT];
	wire       oea   = con0_q[OEA_BIT];
	wire       polb  = con0_q[POLB_BIT];
	wire       pola  = con0_q[POLA_BIT];
	wire       csel  = con0_q[CS_BIT];
	wire [1:0] lvlb  = con1_q[LVLB_LSB +: 2];
	wire [1:0] lvla  = con1_q[LVLA_LSB +: 2];
	wire [1:0] isel  = con1_q[IS_LSB +: 2];
	wire       arsen = con2_q[ARS_BIT];
	wire       c2en  = con2_q[C2_BIT];
	wire       c1en  = con2_q[C1_BIT];
	wire       flten = con2_q[FLT_BIT];

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			con0_q <= CON0_RESET;
			con1_q <= CON1_RESET;
			con2_q <= CON2_RESET;
			dbr_q  <= DB_RESET;
			dbf_q  <= DB_RESET;
		end
		else
		begin
			if (wr_con0)
				con0_q <= pwdata_i[7:0] & CON0_MASK;
			if (wr_con1)
				con1_q <= pwdata_i[7:0] & CON1_MASK;
			if (wr_con2)
				con2_q <= pwdata_i[7:0] & CON2_MASK;
			if (wr_dbr)
				dbr_q <= pwdata_i[5:0];
			if (wr_dbf)
				dbf_q <= pwdata_i[5:0];
		end
	end

	// ==================================================================
	// Input synchronisers
	logic [4:0] meta_q;
	logic [4:0] sync_q;
	wire  [4:0] pins = {fault_pin_n_i, comparator_two_raw_i,
		comparator_one_raw_i, pulse_source_two_i, pulse_source_one_i};

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			meta_q <= SYNC_RESET;
			sync_q <= SYNC_RESET;
		end
		else
		begin
			meta_q <= pins;
			sync_q <= meta_q;
		end
	end

	wire pulse_one_s = sync_q[0];
	wire pulse_two_s = sync_q[1];
	wire cmp_one_s   = sync_q[2];
	wire cmp_two_s   = sync_q[3];
	wire fault_n_s   = sync_q[4];

	// ==================================================================
	// Generator tick: every cycle, or at the fast oscillator rate
	logic [15:0] acc_q;
	wire  [15:0] acc_sum  = acc_q + OSC_KHZ;
	wire         osc_tick = (acc_sum >= SYS_CLK_KHZ);
	wire  [15:0] acc_d    = osc_tick ? (acc_sum - SYS_CLK_KHZ) : acc_sum;
	// Free running; no processor state gates it
	wire         gen_tick = csel ? osc_tick : 1'b1;

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			acc_q <= 16'h0000;
		else
			acc_q <= acc_d;
	end

	// ==================================================================
	// Input source selection and edge detection
	logic src_prev_q;
	wire  src_sel =
		(isel == IS_PULSE_TWO) ? pulse_two_s :
		(isel == IS_PULSE_ONE) ? pulse_one_s :
		(isel == IS_CMP_ONE)   ? cmp_one_s   : cmp_two_s;
	wire  src_now  = gen_tick ? src_sel : src_prev_q;
	wire  src_rise = gen_tick & src_sel & ~src_prev_q;
	wire  src_fall = gen_tick & ~src_sel & src_prev_q;

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			src_prev_q <= 1'b0;
		else if (gen_tick)
			src_prev_q <= src_sel;
	end

	// ==================================================================
	// Dead-band counters
	logic rise_busy;
	logic fall_busy;

	deadband_counter #(.CNT_W(DB_W)) rise_counter (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.clear_i   (~en),
		.tick_i    (gen_tick),
		.start_i   (src_rise & en),
		.value_i   (dbr_q[DB_W-1:0]),
		.busy_o    (rise_busy)
	);

	deadband_counter #(.CNT_W(DB_W)) fall_counter (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.clear_i   (~en),
		.tick_i    (gen_tick),
		.start_i   (src_fall & en),
		.value_i   (dbf_q[DB_W-1:0]),
		.busy_o    (fall_busy)
	);

	// ==================================================================
	// Shutdown sources and event bit
	wire raw_active = (c1en & comparator_one_raw_i) |
		(c2en & comparator_two_raw_i) |
		(flten & ~fault_pin_n_i);
	wire hw_s = (c1en & cmp_one_s) | (c2en & cmp_two_s) | (flten & ~fault_n_s);
	wire ase_set   = hw_s | (wr_con2 & pwdata_i[ASE_BIT]);
	wire ase_swclr = wr_con2 & ~pwdata_i[ASE_BIT] & ~hw_s;
	wire ase_auto  = arsen & ~hw_s;
	wire ase_d     = ase_set ? 1'b1 :
		((ase_swclr | ase_auto) ? 1'b0 : ase_q);

	logic shut_q;
	wire  shut_d  = ase_q ? 1'b1 : (src_rise ? 1'b0 : shut_q);
	wire  shut_any = shut_q | ase_q | raw_active;

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			ase_q  <= 1'b0;
			shut_q <= 1'b1;
		end
		else
		begin
			ase_q  <= ase_d;
			shut_q <= shut_d;
		end
	end

	// ==================================================================
	// Complementary drives with dead band
	logic norm_a_q;
	logic norm_b_q;
	wire  a_drive = en & src_now & ~rise_busy;
	wire  b_drive = en & ~src_now & ~fall_busy;

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			norm_a_q <= 1'b0;
			norm_b_q <= 1'b0;
		end
		else
		begin
			norm_a_q <= a_drive ^ pola;
			norm_b_q <= b_drive ^ polb;
		end
	end

	// ==================================================================
	// Pin drive; shutdown overrides act without a clock
	assign out_a_o = en & (shut_any ? override_level(lvla, pola) :
		norm_a_q);
	assign out_b_o = en & (shut_any ? override_level(lvlb, polb) :
		norm_b_q);
	assign out_a_oe_o = en & oea & ~(shut_any & (lvla == LVL_TRI));
	assign out_b_oe_o = en & oeb & ~(shut_any & (lvlb == LVL_TRI));

	assign prdata_o  = prdata_q;
	assign pready_o  = pready_q;
	assign pslverr_o = pslverr_q;

	// ==================================================================
	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);

	sequence rise_seen;
		en && src_rise;
	endsequence

	sequence quiet_con2;
		!wr_con2;
	endsequence

	sw_event_set_a: assert property (wr_con2 && pwdata_i[ASE_BIT]
		|=> ase_q && out_a_o == (en && override_level(lvla, pola)))
		else $error("event write did not force shutdown");
	event_hold_a: assert property (ase_q && !arsen ##0 quiet_con2 |=> ase_q)
		else $error("event bit dropped without auto-restart");
	auto_clear_a: assert property (ase_q && arsen && !hw_s ##0 quiet_con2
		|=> !ase_q)
		else $error("auto-restart did not clear event bit");
	raw_force_a: assert property (en && raw_active && lvla == LVL_HIGH
		|-> out_a_o && out_a_oe_o == oea)
		else $error("shutdown input did not force override");
	level_hold_a: assert property (hw_s [*2] |-> ase_q [*2])
		else $error("active shutdown source left shutdown");
	sw_clear_block_a: assert property (wr_con2 && !pwdata_i[ASE_BIT] && hw_s
		|=> ase_q)
		else $error("software cleared event with source active");
	resume_hold_a: assert property (shut_q && !ase_q && !src_rise
		|=> shut_q && $stable(shut_q))
		else $error("override released without rising edge");
	tristate_code_a: assert property (shut_any && lvlb == LVL_TRI
		|-> !out_b_oe_o)
		else $error("tri-state code drove the pin");
	disabled_pins_a: assert property (!en |-> !out_a_oe_o && !out_b_oe_o
		&& !out_a_o && !out_b_o)
		else $error("disabled module touched the pins");
	rise_b_off_a: assert property (rise_seen |=> norm_b_q == polb)
		else $error("output b not off after rising edge");
	no_band_a: assert property (rise_seen ##0 dbr_q == 6'h00
		|=> norm_a_q == !pola)
		else $error("zero dead band delayed output a");
	fall_a_off_a: assert property (en && src_fall |=> norm_a_q == pola)
		else $error("output a not off after falling edge");
	reserved_zero_a: assert property (answer && !pwrite_i && hit_con0
		|=> prdata_q[2:1] == 2'b00 && prdata_q[31:8] == 24'h000000)
		else $error("reserved bits read nonzero");

endmodule

// *** logic/complementary_generator_pkg.sv ***
// Constants shared by the complementary generator and its dead-band counter
// ======================================================================
// Summary of operation
// - Writing one to the event bit forces shutdown with override levels.
// - Without auto-restart, shutdown persists while the event bit stays set.
// - With auto-restart, event bit clears itself once all sources are low.
// - An enabled shutdown input forces override levels at once.
// - Shutdown inputs are levels; active source keeps shutdown until disabled.
// - Software clear of the event bit works only with all sources low.
// - After the event bit clears, overrides hold until next rising input edge.
// - Override code 11 drives high, 10 drives low, polarity ignored.
// - Code 01 tri-states the pin; 00 drives the inactive level.
// - Input select: 11 pulse two, 10 pulse one, 01 cmp one, 00 cmp two.
// - Module enable bit turns the generator on or off.
// - Per-output enable routes the waveform to the pin, else leaves it.
// - Per-output invert bit inverts that output's active waveform.
// - Clock select picks fast oscillator rate or system clock for counting.
// - Comparator shutdown enables cause shutdown while that comparator is high.
// - Fault shutdown enable causes shutdown while the fault pin is low.
// - Generator keeps running regardless of processor sleep.
// - Unimplemented control register bits read as zero.
// - Rising edge: B off at once, A on after rising dead band.
// - Falling edge: A off at once, B on after falling dead band.
// - Each edge has its own 6-bit counter; zero means no dead band.
// - Disabled module leaves the pins alone; enabling starts drives cleared.
package complementary_generator_pkg;

	// ==================================================================
	// Register offsets
	localparam logic [7:0] OFF_CON0 = 8'h00;
	localparam logic [7:0] OFF_CON1 = 8'h04;
	localparam logic [7:0] OFF_CON2 = 8'h08;
	localparam logic [7:0] OFF_DBR  = 8'h0c;
	localparam logic [7:0] OFF_DBF  = 8'h10;

	// ==================================================================
	// Field positions
	localparam int EN_BIT    = 7;
	localparam int OEB_BIT   = 6;
	localparam int OEA_BIT   = 5;
	localparam int POLB_BIT  = 4;
	localparam int POLA_BIT  = 3;
	localparam int CS_BIT    = 0;
	localparam int LVLB_LSB  = 6;
	localparam int LVLA_LSB  = 4;
	localparam int IS_LSB    = 0;
	localparam int ASE_BIT   = 7;
	localparam int ARS_BIT   = 6;
	localparam int C2_BIT    = 3;
	localparam int C1_BIT    = 2;
	localparam int FLT_BIT   = 1;

	// ==================================================================
	// Implemented bit masks and reset values
	localparam logic [7:0] CON0_MASK  = 8'hf9;
	localparam logic [7:0] CON1_MASK  = 8'hf3;
	localparam logic [7:0] CON2_MASK  = 8'h4e;
	localparam logic [7:0] CON0_RESET = 8'h00;
	localparam logic [7:0] CON1_RESET = 8'h00;
	localparam logic [7:0] CON2_RESET = 8'h00;
	localparam logic [5:0] DB_RESET   = 6'h00;
	localparam logic [4:0] SYNC_RESET = 5'h10;

	// ==================================================================
	// Override and input select codes
	localparam logic [1:0] LVL_HIGH     = 2'b11;
	localparam logic [1:0] LVL_LOW      = 2'b10;
	localparam logic [1:0] LVL_TRI      = 2'b01;
	localparam logic [1:0] LVL_INACTIVE = 2'b00;
	localparam logic [1:0] IS_PULSE_TWO = 2'b11;
	localparam logic [1:0] IS_PULSE_ONE = 2'b10;
	localparam logic [1:0] IS_CMP_ONE   = 2'b01;
	localparam logic [1:0] IS_CMP_TWO   = 2'b00;

	// ==================================================================
	// Clock rates for the fast oscillator rate enable
	localparam logic [15:0] SYS_CLK_KHZ = 16'd40000;
	localparam logic [15:0] OSC_KHZ     = 16'd16000;

endpackage

// *** logic/deadband_counter.sv ***
// Dead-band counter that times one edge's delay in generator ticks
`timescale 1ns/1ps
module deadband_counter
	import complementary_generator_pkg::*;
#(
	parameter int CNT_W = 6
)
(
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	input  wire logic             clear_i,
	input  wire logic             tick_i,
	input  wire logic             start_i,
	input  wire logic [CNT_W-1:0] value_i,
	output logic                  busy_o
);

	if (CNT_W < 1 || CNT_W > 8)
	begin : width_check
		$error("deadband_counter: CNT_W must be 1 to 8");
	end

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic             busy_q;
	logic             busy_d;
	wire  [CNT_W-1:0] cnt_inc = CNT_W'(cnt_q + 1'b1);
	wire              nonzero = (value_i != '0);

	// ==================================================================
	// Count ticks from zero up to the programmed value
	assign cnt_d  = start_i ? '0 : ((tick_i && busy_q) ? cnt_inc : cnt_q);
	assign busy_d = clear_i ? 1'b0 :
		(start_i ? nonzero :
		((tick_i && busy_q) ? (cnt_inc != value_i) : busy_q));

	assign busy_o = busy_q | (start_i & nonzero & ~clear_i);

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			cnt_q  <= '0;
			busy_q <= 1'b0;
		end
		else
		begin
			cnt_q  <= cnt_d;
			busy_q <= busy_d;
		end
	end

endmodule

// *** testbench/power_switch_model.sv ***
// Model of the power switch drivers on the two generator outputs
`timescale 1ns/1ps
module power_switch_model
(
	input  wire logic drive_a_i,
	input  wire logic enable_a_i,
	input  wire logic drive_b_i,
	input  wire logic enable_b_i,
	output logic      pin_a_o,
	output logic      pin_b_o,
	output logic      overlap_o
);
	// ==================================================================
	// Gate inputs fall to their pull-down when released
	assign pin_a_o = enable_a_i ? drive_a_i : 1'b0;
	assign pin_b_o = enable_b_i ? drive_b_i : 1'b0;

	// ==================================================================
	// Both switches on at once
	assign overlap_o = pin_a_o & pin_b_o;
endmodule

// *** testbench/complementary_waveform_shutdown_ctrl_tb.sv ***
// Self-checking testbench for the complementary waveform generator
`timescale 1ns/1ps
module complementary_waveform_shutdown_ctrl_tb;
	import complementary_generator_pkg::*;
	typedef struct packed {logic rd; logic err; logic [31:0] data;} note_t;
	logic        clk_i, reset_n_i, psel_i, penable_i, pwrite_i;
	logic [7:0]  paddr_i;
	logic [31:0] pwdata_i, prdata_o;
	logic        pready_o, pslverr_o, out_a_o, out_a_oe_o, out_b_o, out_b_oe_o;
	logic [3:0]  src;
	logic        fault_n, pin_a, pin_b, overlap, ovl;
	note_t       notes [$];
	note_t       nt;
	int          mismatches, num_checks, seed, n, n2, gap;
	logic [7:0]  offs [5] = '{OFF_CON0, OFF_CON1, OFF_CON2, OFF_DBR, OFF_DBF};
	logic [7:0]  masks [5] = '{CON0_MASK, CON1_MASK, CON2_MASK, 8'h3f, 8'h3f};
	logic [3:0]  sel_bit [4] = '{4'h8, 4'h4, 4'h1, 4'h2};

	// ==================================================================
	// Clock, design and far side
	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	complementary_waveform_shutdown_ctrl complementary_waveform_shutdown_ctrl_i
	(
		.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .pulse_source_one_i(src[0]),
		.pulse_source_two_i(src[1]), .comparator_one_raw_i(src[2]),
		.comparator_two_raw_i(src[3]), .fault_pin_n_i(fault_n),
		.out_a_o(out_a_o), .out_a_oe_o(out_a_oe_o), .out_b_o(out_b_o),
		.out_b_oe_o(out_b_oe_o)
	);

	power_switch_model power_switch_model_i
	(
		.drive_a_i(out_a_o), .enable_a_i(out_a_oe_o), .drive_b_i(out_b_o),
		.enable_b_i(out_b_oe_o), .pin_a_o(pin_a), .pin_b_o(pin_b),
		.overlap_o(overlap)
	);

	// ==================================================================
	// Reporting and comparison
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic cmp_bit(input logic got, input logic exp, input string m);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: read %h not %h", $time, got, exp);
		end
	endtask

	// ==================================================================
	// Bus master and reply watcher
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [7:0] d, input logic [7:0] exp, input logic err);
		int k;
		notes.push_back('{!wr, err, {24'h0, exp}});
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= {24'h0, d};
		@(posedge clk_i);
		penable_i <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk_i);
			k++;
		end
		while (pready_o !== 1'b1 && k < 20);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		if (k == 20)
		begin
			cmp_bit(1'b0, 1'b1, "bus timeout");
			final_report();
		end
	endtask

	always @(posedge clk_i)
		if (psel_i && penable_i && pready_o === 1'b1)
		begin
			nt = notes.pop_front();
			cmp_bit(pslverr_o, nt.err, "error flag");
			if (nt.rd)
				cmp_word(prdata_o, nt.data);
		end

	// ==================================================================
	// Input drive and output waits
	task automatic set_in(input logic [3:0] v, input logic f);
		@(posedge clk_i);
		src <= v;
		fault_n <= f;
	endtask

	task automatic expect_ab(input logic a, input logic b);
		@(negedge clk_i);
		cmp_bit(pin_a, a, "pin a");
		cmp_bit(pin_b, b, "pin b");
	endtask

	task automatic wait_pin(input logic sel_b, input logic v, output int c);
		c = 0;
		while ((sel_b ? pin_b : pin_a) !== v && c < 300)
		begin
			@(negedge clk_i);
			ovl |= overlap;
			c++;
		end
		if (c == 300)
		begin
			cmp_bit(1'b0, 1'b1, "output timeout");
			final_report();
		end
	endtask

	task automatic edge_gap(input logic up, input int n, input logic cs);
		int c0, c1, lo;
		lo = cs ? n * SYS_CLK_KHZ / OSC_KHZ - 2 : n;
		ovl = 1'b0;
		set_in({src[3:1], up}, 1'b1);
		wait_pin(up, 1'b0, c0);
		wait_pin(!up, 1'b1, c1);
		cmp_bit(c0 <= (cs ? 6 : 4), 1'b1, "late turn-off");
		cmp_bit(c1 >= lo && c1 <= lo + 5, 1'b1, "dead band");
		cmp_bit(ovl, 1'b0, "overlap");
	endtask

	// ==================================================================
	// Main sequence
	initial
	begin
		seed = 32'h4ad2;
		{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
		src = 4'h0;
		fault_n = 1'b1;
		reset_n_i = 1'b0;
		repeat (20) @(posedge clk_i);
		reset_n_i <= 1'b1;
		foreach (offs[i]) apb(0, offs[i], 0, 8'h00, 0);
		foreach (offs[i]) apb(1, offs[i], 8'hff, 0, 0);
		foreach (offs[i]) apb(0, offs[i], 0, masks[i], 0);
		apb(1, 8'h14, 8'hff, 0, 1);
		apb(0, 8'h14, 0, 8'h00, 1);
		n = 1 + ($random(seed) & 15);
		n2 = 1 + ($random(seed) & 15);
		apb(1, OFF_CON0, 8'h00, 0, 0);
		expect_ab(1'b0, 1'b0);
		apb(1, OFF_DBR, n[7:0], 0, 0);
		apb(1, OFF_DBF, n2[7:0], 0, 0);
		apb(1, OFF_CON2, 8'h80, 0, 0);
		apb(1, OFF_CON1, 8'ha2, 0, 0);
		apb(1, OFF_CON0, 8'hf0, 0, 0);
		for (int c = 3; c >= 0; c--)
		begin
			apb(1, OFF_CON1, {c[1:0], c[1:0], 4'h2}, 0, 0);
			expect_ab(c == 3, c == 3 || c == 0);
			cmp_bit(out_a_oe_o, c != 1, "tri-state");
		end
		apb(1, OFF_CON1, 8'ha2, 0, 0);
		apb(1, OFF_CON0, 8'he0, 0, 0);
		apb(1, OFF_CON2, 8'h00, 0, 0);
		apb(0, OFF_CON2, 0, 8'h00, 0);
		repeat (5) expect_ab(1'b0, 1'b0);
		edge_gap(1, n, 0);
		edge_gap(0, n2, 0);
		apb(1, OFF_CON0, 8'he8, 0, 0);
		repeat (4) @(negedge clk_i);
		cmp_bit(pin_a, 1'b1, "inverted a");
		apb(1, OFF_CON0, 8'he1, 0, 0);
		edge_gap(1, n, 1);
		edge_gap(0, n2, 1);
		apb(1, OFF_CON0, 8'he0, 0, 0);
		apb(1, OFF_DBR, 8'h00, 0, 0);
		edge_gap(1, 0, 0);
		edge_gap(0, n2, 0);
		for (int s = 0; s < 4; s++)
		begin
			apb(1, OFF_CON1, 8'ha0 | s[7:0], 0, 0);
			set_in(~sel_bit[s], 1'b1);
			repeat (6) @(negedge clk_i);
			cmp_bit(pin_a, 1'b0, "wrong source");
			set_in(4'hf, 1'b1);
			wait_pin(0, 1'b1, gap);
			set_in(4'h0, 1'b1);
			wait_pin(1, 1'b1, gap);
		end
		apb(1, OFF_DBR, n[7:0], 0, 0);
		apb(1, OFF_CON1, 8'hb2, 0, 0);
		apb(1, OFF_CON2, 8'h04, 0, 0);
		set_in(4'h4, 1'b1);
		expect_ab(1'b1, 1'b0);
		repeat (6) @(negedge clk_i);
		apb(0, OFF_CON2, 0, 8'h84, 0);
		apb(1, OFF_CON2, 8'h04, 0, 0);
		apb(0, OFF_CON2, 0, 8'h84, 0);
		apb(1, OFF_CON2, 8'h00, 0, 0);
		apb(0, OFF_CON2, 0, 8'h80, 0);
		apb(1, OFF_CON2, 8'h00, 0, 0);
		apb(0, OFF_CON2, 0, 8'h00, 0);
		repeat (5) expect_ab(1'b1, 1'b0);
		set_in(4'h0, 1'b1);
		apb(1, OFF_CON1, 8'ha2, 0, 0);
		edge_gap(1, n, 0);
		apb(1, OFF_CON2, 8'h42, 0, 0);
		set_in(4'h1, 1'b0);
		expect_ab(1'b0, 1'b0);
		repeat (4) @(negedge clk_i);
		set_in(4'h0, 1'b1);
		repeat (8) @(negedge clk_i);
		apb(0, OFF_CON2, 0, 8'h42, 0);
		edge_gap(1, n, 0);
		apb(1, OFF_CON2, 8'h00, 0, 0);
		set_in(4'h1, 1'b0);
		expect_ab(1'b1, 1'b0);
		set_in(4'h1, 1'b1);
		apb(1, OFF_CON2, 8'h80, 0, 0);
		repeat (20) @(negedge clk_i);
		expect_ab(1'b0, 1'b0);
		apb(0, OFF_CON2, 0, 8'h80, 0);
		apb(1, OFF_CON0, 8'hc0, 0, 0);
		@(negedge clk_i);
		cmp_bit(out_a_oe_o, 1'b0, "a enable");
		cmp_bit(out_b_oe_o, 1'b1, "b enable");
		apb(1, OFF_CON0, 8'h60, 0, 0);
		@(negedge clk_i);
		cmp_bit(out_a_oe_o | out_b_oe_o, 1'b0, "disabled");
		final_report();
	end
endmodule
